// ===== design/plc_packet_framer.sv
// Purpose: BPSK packet framer, deframer, indicators and AXI4-Lite registers
// Assumes: front end delivers demodulated bits with a strobe per bit
// Notes:   carrier is a square wave; analogue shaping happens outside
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
module plc_packet_framer
	import plc_framer_pkg::*;
#(
	parameter int STARTUP_CYCLES_P = STARTUP_CYC,
	parameter int BLINK_HALF_P     = BLINK_HALF
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [11:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [11:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// line side
	input  wire logic        line_rx_bit,
	input  wire logic        line_rx_strobe,
	output logic             line_tx_out,
	output logic             line_tx_en,
	// option inputs, high when jumper fitted
	input  wire logic        address_select_high,
	input  wire logic        address_select_low,
	// indicators
	output logic             rx_good_led,
	output logic             rx_busy_led,
	output logic             tx_led,
	output logic             lamp_out,
	output logic             irq
);
	function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] b);
		logic [15:0] r;
		r = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	// start bit 0, data msb first, even parity, stop bit 1
	function automatic logic [10:0] encode(logic [7:0] b);
		return {1'b0, b, ^b, 1'b1};
	endfunction

	logic [7:0] tx_mem [0:127];
	logic [7:0] rx_mem [0:127];

	// timing group
	logic [8:0]  carr_reg, carr_next;
	logic [4:0]  cyc_reg, cyc_next;
	logic [26:0] up_reg, up_next, blk_reg, blk_next;
	logic [8:0]  node_addr_reg, node_addr_next;
	logic        carrier_reg, carrier_next, lamp_reg, lamp_next;
	logic        blink_reg, blink_next, busy_led_reg, busy_led_next;
	logic        tx_led_reg, tx_led_next, act;
	logic        carrier_tick, bit_tick;
	// bus group
	logic [11:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next, rdata_reg, rdata_next;
	logic [3:0]  w_strb_reg, w_strb_next;
	logic        aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic        tx_req_reg, tx_req_next, rx_en_reg, rx_en_next;
	logic [7:0]  tx_len_reg, tx_len_next, tx_hdr_reg, tx_hdr_next;
	logic [2:0]  irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
	logic [2:0]  irq_clr, irq_ev;
	logic        wr_fire, rd_fire;
	// transmit group
	tx_state_t   tx_state_reg, tx_state_next;
	logic [23:0] tx_sr_reg, tx_sr_next;
	logic [4:0]  tx_cnt_reg, tx_cnt_next;
	logic [7:0]  tx_idx_reg, tx_idx_next, tx_byte;
	logic [15:0] tx_crc_reg, tx_crc_next;
	logic        tx_two_reg, tx_two_next, tx_go, tx_done_ev;
	logic        line_reg, line_next, line_en_reg, line_en_next;
	// receive group
	rx_state_t   rx_state_reg, rx_state_next;
	logic [23:0] rx_hist_reg, rx_hist_next;
	logic [10:0] rx_word_reg, rx_word_next, rx_wn;
	logic [5:0]  rx_cnt_reg, rx_cnt_next;
	logic [7:0]  rx_idx_reg, rx_idx_next, rx_len_reg, rx_len_next;
	logic [7:0]  rx_hdr_reg, rx_hdr_next;
	logic [15:0] rx_crc_reg, rx_crc_next;
	logic        rx_pol_reg, rx_pol_next, rx_bad_reg, rx_bad_next;
	logic        rx_good_reg, rx_good_next, rx_end, rx_ok, rx_wr;

	assign carrier_tick = carr_reg == 9'(CARRIER_DIV - 1);
	assign bit_tick = carrier_tick && cyc_reg == 5'(BIT_CYCLES - 1);

	always_comb begin
		carr_next = carrier_tick ? 9'h000 : carr_reg + 9'h001;
		carrier_next = carrier_reg;
		if (carrier_tick || carr_reg == 9'(CARRIER_DIV / 2 - 1)) begin
			carrier_next = !carrier_reg;
		end
		cyc_next = cyc_reg;
		if (carrier_tick) begin
			cyc_next = bit_tick ? 5'h00 : cyc_reg + 5'h01;
		end
		up_next = up_reg;
		lamp_next = lamp_reg;
		blk_next = blk_reg;
		blink_next = blink_reg;
		if (!lamp_reg) begin
			up_next = up_reg + 27'h0000001;
			lamp_next = up_reg == 27'(STARTUP_CYCLES_P - 1);
		end else if (blk_reg == 27'(BLINK_HALF_P - 1)) begin
			blk_next = 27'h0000000;
			blink_next = !blink_reg;
		end else begin
			blk_next = blk_reg + 27'h0000001;
		end
		act = lamp_reg && blink_reg && tx_state_reg == TX_IDLE &&
			rx_state_reg == RX_SEARCH;
		busy_led_next = rx_state_reg != RX_SEARCH || act;
		tx_led_next = tx_state_reg != TX_IDLE || act;
		node_addr_next = NODE_BASE +
			{7'h00, address_select_high, address_select_low};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			carr_reg <= 9'h000;
			cyc_reg <= 5'h00;
			carrier_reg <= 1'b0;
			up_reg <= 27'h0000000;
			blk_reg <= 27'h0000000;
			lamp_reg <= 1'b0;
			blink_reg <= 1'b0;
			busy_led_reg <= 1'b0;
			tx_led_reg <= 1'b0;
			node_addr_reg <= NODE_BASE;
		end else begin
			carr_reg <= carr_next;
			cyc_reg <= cyc_next;
			carrier_reg <= carrier_next;
			up_reg <= up_next;
			blk_reg <= blk_next;
			lamp_reg <= lamp_next;
			blink_reg <= blink_next;
			busy_led_reg <= busy_led_next;
			tx_led_reg <= tx_led_next;
			node_addr_reg <= node_addr_next;
		end
	end

	// bus: address and data may arrive in either order
	assign awready = !aw_have_reg;
	assign wready = !w_have_reg;
	assign arready = !rvalid_reg;
	assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
	assign rd_fire = arvalid && !rvalid_reg;
	assign irq_ev = {rx_end && !rx_ok, rx_end && rx_ok, tx_done_ev};

	always_comb begin
		aw_have_next = aw_have_reg;
		aw_addr_next = aw_addr_reg;
		w_have_next = w_have_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		if (awvalid && !aw_have_reg) begin
			aw_have_next = 1'b1;
			aw_addr_next = awaddr;
		end
		if (wvalid && !w_have_reg) begin
			w_have_next = 1'b1;
			w_data_next = wdata;
			w_strb_next = wstrb;
		end
		bvalid_next = bvalid_reg && !bready;
		bresp_next = bresp_reg;
		tx_req_next = tx_req_reg && !tx_go;
		rx_en_next = rx_en_reg;
		tx_len_next = tx_len_reg;
		tx_hdr_next = tx_hdr_reg;
		irq_mask_next = irq_mask_reg;
		irq_clr = 3'h0;
		if (wr_fire) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = RESP_OKAY;
			case (aw_addr_reg)
				A_CTRL: if (w_strb_reg[0]) begin
					tx_req_next = tx_req_next || w_data_reg[CTRL_TX_GO];
					rx_en_next = w_data_reg[CTRL_RX_EN];
				end
				A_TXCFG: begin
					if (w_strb_reg[0]) begin
						tx_len_next = w_data_reg[7:0] > MAX_DATA ?
							MAX_DATA : w_data_reg[7:0];
					end
					if (w_strb_reg[1]) begin
						tx_hdr_next = w_data_reg[15:8];
					end
				end
				A_IRQ_STAT: if (w_strb_reg[0]) begin
					irq_clr = w_data_reg[2:0];
				end
				A_IRQ_MASK: if (w_strb_reg[0]) begin
					irq_mask_next = w_data_reg[2:0];
				end
				A_STATUS, A_RXINFO: ;
				default: if (aw_addr_reg[11:9] != PAGE_TX) begin
					bresp_next = RESP_SLVERR;
				end
			endcase
		end
		// a new event wins over a clear in the same cycle
		irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev;
		rvalid_next = rvalid_reg && !rready;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (rd_fire) begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			case (araddr)
				A_CTRL: rdata_next = {30'h0, rx_en_reg, tx_req_reg};
				A_TXCFG: rdata_next = {16'h0000, tx_hdr_reg, tx_len_reg};
				A_STATUS: rdata_next = {7'h00, node_addr_reg, 12'h000,
					lamp_reg, tx_state_reg != TX_IDLE,
					rx_state_reg != RX_SEARCH, rx_good_reg};
				A_RXINFO: rdata_next = {16'h0000, rx_hdr_reg, rx_len_reg};
				A_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
				A_IRQ_MASK: rdata_next = {29'h0, irq_mask_reg};
				default: begin
					rdata_next = 32'h00000000;
					if (araddr[11:9] == PAGE_TX) begin
						rdata_next = {24'h000000, tx_mem[araddr[8:2]]};
					end else if (araddr[11:9] == PAGE_RX) begin
						rdata_next = {24'h000000, rx_mem[araddr[8:2]]};
					end else begin
						rresp_next = RESP_SLVERR;
					end
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_have_reg <= 1'b0;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= RESP_OKAY;
			tx_req_reg <= 1'b0;
			rx_en_reg <= 1'b0;
			tx_len_reg <= 8'h00;
			tx_hdr_reg <= 8'h00;
			irq_stat_reg <= 3'h0;
			irq_mask_reg <= 3'h0;
		end else begin
			aw_have_reg <= aw_have_next;
			aw_addr_reg <= aw_addr_next;
			w_have_reg <= w_have_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			tx_req_reg <= tx_req_next;
			rx_en_reg <= rx_en_next;
			tx_len_reg <= tx_len_next;
			tx_hdr_reg <= tx_hdr_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
		end
		if (wr_fire && aw_addr_reg[11:9] == PAGE_TX && w_strb_reg[0]) begin
			tx_mem[aw_addr_reg[8:2]] <= w_data_reg[7:0];
		end
		if (rx_wr) begin
			rx_mem[7'(rx_idx_reg - 8'h01)] <= rx_wn[9:2];
		end
	end

	// transmit: waits until the receiver is back in search, so with receive enabled it never starts transmitting over a packet past its preamble
	assign tx_go = tx_req_reg && bit_tick && tx_state_reg == TX_IDLE &&
		rx_state_reg == RX_SEARCH;

	always_comb begin
		if (tx_idx_reg == 8'h00) begin
			tx_byte = tx_hdr_reg;
		end else if (tx_idx_reg <= tx_len_reg) begin
			tx_byte = tx_mem[7'(tx_idx_reg - 8'h01)];
		end else if (tx_idx_reg == tx_len_reg + 8'h01) begin
			tx_byte = tx_crc_reg[15:8];
		end else begin
			tx_byte = tx_crc_reg[7:0];
		end
		tx_state_next = tx_state_reg;
		tx_sr_next = tx_sr_reg;
		tx_cnt_next = tx_cnt_reg;
		tx_idx_next = tx_idx_reg;
		tx_crc_next = tx_crc_reg;
		tx_two_next = tx_two_reg;
		tx_done_ev = 1'b0;
		if (bit_tick && tx_state_reg != TX_IDLE && tx_cnt_reg > 5'h01) begin
			tx_sr_next = tx_sr_reg << 1;
			tx_cnt_next = tx_cnt_reg - 5'h01;
		end else if (bit_tick) begin
			tx_cnt_next = WORD_BITS;
			case (tx_state_reg)
				TX_IDLE: if (tx_go) begin
					tx_state_next = TX_PRE;
					tx_sr_next = PREAMBLE;
					tx_cnt_next = PRE_BITS;
					tx_idx_next = 8'h00;
					tx_crc_next = CRC_INIT;
				end
				TX_PRE: begin
					tx_state_next = TX_SYNC;
					tx_sr_next = {WORD_SYNC, 13'h0000};
				end
				TX_SYNC, TX_DATA: begin
					if ({1'b0, tx_idx_reg} <= {1'b0, tx_len_reg} + 9'h002) begin
						tx_state_next = TX_DATA;
						tx_sr_next = {encode(tx_byte), 13'h0000};
						tx_idx_next = tx_idx_reg + 8'h01;
						if (tx_idx_reg <= tx_len_reg) begin
							tx_crc_next = crc_byte(tx_crc_reg, tx_byte);
						end
					end else begin
						tx_state_next = TX_END;
						tx_sr_next = {END_MARK, 13'h0000};
						tx_two_next = 1'b0;
					end
				end
				TX_END: if (!tx_two_reg) begin
					tx_sr_next = {END_MARK, 13'h0000};
					tx_two_next = 1'b1;
				end else begin
					tx_state_next = TX_IDLE;
					tx_done_ev = 1'b1;
				end
				default: tx_state_next = TX_IDLE;
			endcase
		end
		line_en_next = tx_state_next != TX_IDLE;
		line_next = line_en_next && (carrier_next ^ tx_sr_next[23]);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state_reg <= TX_IDLE;
			tx_sr_reg <= 24'h000000;
			tx_cnt_reg <= 5'h00;
			tx_idx_reg <= 8'h00;
			tx_crc_reg <= CRC_INIT;
			tx_two_reg <= 1'b0;
			line_reg <= 1'b0;
			line_en_reg <= 1'b0;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_sr_reg <= tx_sr_next;
			tx_cnt_reg <= tx_cnt_next;
			tx_idx_reg <= tx_idx_next;
			tx_crc_reg <= tx_crc_next;
			tx_two_reg <= tx_two_next;
			line_reg <= line_next;
			line_en_reg <= line_en_next;
		end
	end

	// receive
	assign rx_hist_next = {rx_hist_reg[22:0], line_rx_bit};
	assign rx_wn = {rx_word_reg[9:0], line_rx_bit ^ rx_pol_reg};

	always_comb begin
		rx_state_next = rx_state_reg;
		rx_word_next = rx_word_reg;
		rx_cnt_next = rx_cnt_reg;
		rx_idx_next = rx_idx_reg;
		rx_crc_next = rx_crc_reg;
		rx_pol_next = rx_pol_reg;
		rx_bad_next = rx_bad_reg;
		rx_hdr_next = rx_hdr_reg;
		rx_len_next = rx_len_reg;
		rx_good_next = rx_good_reg;
		rx_end = 1'b0;
		rx_ok = 1'b0;
		rx_wr = 1'b0;
		if (!rx_en_reg) begin
			rx_state_next = RX_SEARCH;
		end else if (line_rx_strobe) begin
			rx_cnt_next = rx_cnt_reg + 6'h01;
			case (rx_state_reg)
				RX_SEARCH: if (rx_hist_next == PREAMBLE ||
					rx_hist_next == ~PREAMBLE) begin
					rx_state_next = RX_SYNC;
					rx_cnt_next = 6'h00;
				end
				RX_SYNC: if (rx_hist_next[10:0] == WORD_SYNC ||
					rx_hist_next[10:0] == ~WORD_SYNC) begin
					rx_state_next = RX_DATA;
					rx_pol_next = rx_hist_next[10:0] != WORD_SYNC;
					rx_cnt_next = 6'h00;
					rx_idx_next = 8'h00;
					rx_crc_next = CRC_INIT;
					rx_bad_next = 1'b0;
				end else if (rx_cnt_reg == SYNC_WAIT) begin
					rx_end = 1'b1;
				end
				RX_DATA: begin
					rx_word_next = rx_wn;
					if (rx_cnt_reg == 6'(WORD_BITS - 5'h01)) begin
						rx_cnt_next = 6'h00;
						if (rx_wn == END_MARK) begin
							rx_end = 1'b1;
							rx_ok = !rx_bad_reg && rx_crc_reg == 16'h0000 &&
								rx_idx_reg >= 8'h03;
						end else if (rx_idx_reg == MAX_DATA + 8'h03) begin
							rx_end = 1'b1;
						end else begin
							rx_bad_next = rx_bad_reg || rx_wn[10] ||
								!rx_wn[0] || ^rx_wn[9:1];
							rx_crc_next = crc_byte(rx_crc_reg, rx_wn[9:2]);
							rx_idx_next = rx_idx_reg + 8'h01;
							if (rx_idx_reg == 8'h00) begin
								rx_hdr_next = rx_wn[9:2];
							end
							rx_wr = rx_idx_reg != 8'h00 && rx_idx_reg <= MAX_DATA;
						end
					end
				end
				default: rx_state_next = RX_SEARCH;
			endcase
			if (rx_end) begin
				rx_state_next = RX_SEARCH;
				rx_good_next = rx_ok;
				if (rx_ok) begin
					rx_len_next = rx_idx_reg - 8'h03;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state_reg <= RX_SEARCH;
			rx_hist_reg <= 24'h000000;
			rx_word_reg <= 11'h000;
			rx_cnt_reg <= 6'h00;
			rx_idx_reg <= 8'h00;
			rx_crc_reg <= CRC_INIT;
			rx_pol_reg <= 1'b0;
			rx_bad_reg <= 1'b0;
			rx_hdr_reg <= 8'h00;
			rx_len_reg <= 8'h00;
			rx_good_reg <= 1'b0;
		end else begin
			rx_state_reg <= rx_state_next;
			if (line_rx_strobe) begin
				rx_hist_reg <= rx_hist_next;
			end
			rx_word_reg <= rx_word_next;
			rx_cnt_reg <= rx_cnt_next;
			rx_idx_reg <= rx_idx_next;
			rx_crc_reg <= rx_crc_next;
			rx_pol_reg <= rx_pol_next;
			rx_bad_reg <= rx_bad_next;
			rx_hdr_reg <= rx_hdr_next;
			rx_len_reg <= rx_len_next;
			rx_good_reg <= rx_good_next;
		end
	end

	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;
	assign line_tx_out = line_reg;
	assign line_tx_en = line_en_reg;
	assign rx_good_led = rx_good_reg;
	assign rx_busy_led = busy_led_reg;
	assign tx_led = tx_led_reg;
	assign lamp_out = lamp_reg;
	assign irq = |(irq_stat_reg & irq_mask_reg);

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// the toggle itself lands on the tick edge, quiet only after it
	a_carrier_half: assert property (carrier_tick |=>
		$changed(carrier_reg) ##1 $stable(carrier_reg)[*8])
		else $error("carrier toggled too soon");
	a_bit_period: assert property (bit_tick |->
		cyc_reg == 5'h17 ##1 cyc_reg == 5'h00)
		else $error("bit period not 24 carrier cycles");
	a_pre_start: assert property (tx_go |=>
		tx_sr_reg == PREAMBLE && tx_cnt_reg == 5'h18)
		else $error("preamble not loaded at start");
	a_sync_follow: assert property (bit_tick &&
		tx_state_reg == TX_PRE && tx_cnt_reg == 5'h01 |=>
		tx_state_reg == TX_SYNC && tx_sr_reg[23:13] == WORD_SYNC)
		else $error("word sync does not follow preamble");
	a_code_form: assert property (
		tx_state_reg == TX_DATA && tx_cnt_reg == 5'h0B |->
		!tx_sr_reg[23] && tx_sr_reg[13] && !(^tx_sr_reg[22:14]))
		else $error("bad codeword framing");
	// marker already shifted out but for its last bit when done fires
	a_end_twice: assert property (tx_done_ev |->
		tx_two_reg && tx_state_reg == TX_END && tx_cnt_reg == 5'h01 &&
		tx_sr_reg[23:13] == {END_MARK[0], 10'h000})
		else $error("end marker not sent twice");
	a_node_addr: assert property (##1 node_addr_reg ==
		9'h100 + {7'h00, $past(address_select_high),
		$past(address_select_low)})
		else $error("node address wrong");
	a_good_update: assert property (rx_end |=>
		rx_good_reg == $past(rx_ok))
		else $error("receive-good not updated");
	a_busy_led: assert property (rx_state_reg != RX_SEARCH |=>
		rx_busy_led)
		else $error("receive-busy dropped");
	// enable tracks the state, the indicator lags it by one register
	a_tx_led: assert property (tx_state_reg != TX_IDLE |->
		line_tx_en ##1 tx_led)
		else $error("transmit indicator dropped");
	a_lamp_hold: assert property (lamp_reg |=> lamp_reg)
		else $error("lamp went off");
	c_tx_done: cover property (tx_done_ev);
	c_rx_good: cover property (rx_end && rx_ok);
	c_rx_bad: cover property (rx_end && !rx_ok);
	c_irq_clear: cover property (wr_fire && irq_clr != 3'h0 && irq);
endmodule

// ===== include/plc_framer_pkg.sv
// Purpose: shared constants and types for the power-line packet framer
// Assumes: 40 MHz aclk, AXI4-Lite register access
// Notes:   codeword and CRC layout are local choices, see field comments
// Functional notes
// - bits ride a 131.5 kHz carrier; phase reversal marks a one.
// - every bit lasts exactly 24 carrier cycles.
// - packets open with 24 alternating bits starting with one; receiver hunts it.
// - word sync 11001111011 follows the preamble directly.
// - each payload byte travels as one 11-bit codeword.
// - content is 8-bit link header, data unit, then 16-bit CRC.
// - end marker 11100110011 is sent twice; receiver ends packet on it.
// - node address is 256 plus two option bits, high input first.
// - receive-good shows whether the last reception was error free.
// - receive-busy stays high for the whole reception.
// - transmit indicator stays high for the whole transmission.
// - lamp on two seconds after reset; idle indicators blink at one second.
// - word sync searched only after preamble; its polarity sets data polarity.
// - receiver checks codeword parity and accepts only a matching CRC.
package plc_framer_pkg;
	localparam int CLK_HZ       = 40_000_000;
	localparam int CARRIER_HZ   = 131_500;
	localparam int CARRIER_DIV  = CLK_HZ / CARRIER_HZ;
	localparam int BIT_CYCLES   = 24;
	localparam int STARTUP_MS   = 2000;
	localparam int BLINK_MS     = 1000;
	localparam int STARTUP_CYC  = STARTUP_MS * (CLK_HZ / 1000);
	localparam int BLINK_HALF   = BLINK_MS * (CLK_HZ / 1000) / 2;
	localparam logic [23:0] PREAMBLE  = 24'hAAAAAA;
	localparam logic [10:0] WORD_SYNC = 11'h67B;
	localparam logic [10:0] END_MARK  = 11'h733;
	localparam logic [4:0]  PRE_BITS  = 5'h18;
	localparam logic [4:0]  WORD_BITS = 5'h0B;
	localparam logic [5:0]  SYNC_WAIT = 6'h30;
	localparam logic [7:0]  MAX_DATA  = 8'h80;
	localparam logic [15:0] CRC_INIT  = 16'hFFFF;
	localparam logic [15:0] CRC_POLY  = 16'h1021;
	localparam logic [8:0]  NODE_BASE = 9'h100;
	// register byte offsets
	localparam logic [11:0] A_CTRL     = 12'h000;
	localparam logic [11:0] A_TXCFG    = 12'h004;
	localparam logic [11:0] A_STATUS   = 12'h008;
	localparam logic [11:0] A_RXINFO   = 12'h00C;
	localparam logic [11:0] A_IRQ_STAT = 12'h010;
	localparam logic [11:0] A_IRQ_MASK = 12'h014;
	localparam logic [2:0]  PAGE_TX    = 3'h1;
	localparam logic [2:0]  PAGE_RX    = 3'h2;
	// field positions
	localparam int CTRL_TX_GO  = 0;
	localparam int CTRL_RX_EN  = 1;
	localparam int IRQ_TX_DONE = 0;
	localparam int IRQ_RX_DONE = 1;
	localparam int IRQ_RX_ERR  = 2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SYNC, TX_DATA, TX_END}
		tx_state_t;
	typedef enum logic [1:0] {RX_SEARCH, RX_SYNC, RX_DATA} rx_state_t;
endpackage

// ===== tb/line_peer.sv
// Purpose: far-side line peer, hands demodulated bits to the framer
// Assumes: one strobe per bit, a chosen gap between bits
// Notes:   data line shows the inverse of the last bit between strobes
module line_peer (
	// clock
	input  wire logic aclk,
	// demodulated line
	output logic      rx_bit,
	output logic      rx_strobe
);
	timeunit 1ns;
	timeprecision 1ps;

	logic bits_q[$];

	initial begin
		rx_bit = 1'b0;
		rx_strobe = 1'b0;
	end

	// a phase-reversed symbol arrives as a one
	task automatic run(input int gap);
		logic b;
		while (bits_q.size() > 0) begin
			b = bits_q.pop_front();
			@(posedge aclk);
			rx_bit <= b;
			rx_strobe <= 1'b1;
			@(posedge aclk);
			rx_strobe <= 1'b0;
			// stale level must not pass for data
			rx_bit <= ~b;
			repeat (gap) @(posedge aclk);
		end
	endtask
endmodule

// ===== tb/tb.sv
// Purpose: self-checking bench for the power-line packet framer
// Assumes: short startup and blink counts, peer feeds received bits
// Notes:   a full transmit is too long, so only its first bits are seen
module tb
	import plc_framer_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0;
	logic        wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
	logic        rready = 1'b0, sel_hi = 1'b0, sel_lo = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [2:0]  awprot = 3'h0, arprot = 3'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'hF;
	logic [1:0]  bresp, rresp;
	logic [1:0]  exp_bresp = RESP_OKAY;
	logic        awready, wready, bvalid, arready, rvalid, rx_bit;
	logic        rx_strobe, tx_out, tx_en, good, busy, tx_led, lamp, irq;
	logic [33:0] exp_q[$], msk_q[$];
	int          err_total = 0, samples_checked = 0, cyc = 0, i;
	integer      seed = 32'hbc322d1b;
	logic [7:0]  hdr, dat;
	logic        v0;
	localparam int BIT_CLK = BIT_CYCLES * CARRIER_DIV;

	plc_packet_framer #(.STARTUP_CYCLES_P(100), .BLINK_HALF_P(50))
	i_plc_packet_framer (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(awprot), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(arprot), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.line_rx_bit(rx_bit), .line_rx_strobe(rx_strobe),
		.line_tx_out(tx_out), .line_tx_en(tx_en),
		.address_select_high(sel_hi), .address_select_low(sel_lo),
		.rx_good_led(good), .rx_busy_led(busy), .tx_led(tx_led),
		.lamp_out(lamp), .irq(irq));
	line_peer i_line_peer (.aclk(aclk), .rx_bit(rx_bit),
		.rx_strobe(rx_strobe));

	always #12.5 aclk = ~aclk;

	task automatic wrap_up;
		if (err_total == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input bit ok, input string m);
		samples_checked++;
		if (!ok) begin
			err_total++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask

	// hang guard, well above the longest sequence
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			wrap_up;
		end
	end

	always @(posedge aclk)
		if (rvalid === 1'b1 && rready === 1'b1) begin
			chk((({rresp, rdata} ^ exp_q[0]) & msk_q[0]) === 34'h0, "rd");
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bit ta;
		bit tw;
		@(posedge aclk);
		ta = 0;
		tw = 0;
		awaddr <= a;
		wdata <= d;
		awprot <= 3'($random(seed));
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready && !ta) begin
				ta = 1;
				awvalid <= 1'b0;
			end
			if (wready && !tw) begin
				tw = 1;
				wvalid <= 1'b0;
			end
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(bresp === exp_bresp, "wr resp");
	endtask

	task automatic rd(input logic [11:0] a, input logic [33:0] e,
		input logic [33:0] m);
		bit t;
		@(posedge aclk);
		t = 0;
		araddr <= a;
		arprot <= 3'($random(seed));
		arvalid <= 1'b1;
		rready <= 1'b1;
		exp_q.push_back(e);
		msk_q.push_back(m);
		do begin
			@(posedge aclk);
			if (arready && !t) begin
				t = 1;
				arvalid <= 1'b0;
			end
		end while (!(t && rvalid === 1'b1));
		rready <= 1'b0;
	endtask

	function automatic logic [15:0] crc16(input logic [15:0] hd);
		logic [15:0] c;
		c = CRC_INIT;
		for (int k = 15; k >= 0; k--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ hd[k]) ? CRC_POLY : 16'h0);
		return c;
	endfunction

	// codeword: zero, byte msb first, parity, one
	task automatic put(input logic [10:0] w, input bit inv, input bit cw);
		logic [10:0] x;
		x = cw ? {1'b0, w[7:0], ^w[7:0], 1'b1} : w;
		for (int k = 10; k >= 0; k--)
			i_line_peer.bits_q.push_back(x[k] ^ inv);
	endtask

	task automatic pkt(input int mode);
		logic [15:0] crc;
		hdr = 8'($random(seed));
		dat = 8'($random(seed));
		crc = crc16({hdr, dat}) ^ ((mode == 2) ? 16'h0001 : 16'h0);
		for (int k = 23; k >= 0; k--)
			i_line_peer.bits_q.push_back(PREAMBLE[k] ^ (mode == 1));
		put(WORD_SYNC, mode == 1, 0);
		put({3'h0, hdr}, mode == 1, 1);
		put({3'h0, dat}, mode == 1, 1);
		put({3'h0, crc[15:8]}, mode == 1, 1);
		put({3'h0, crc[7:0]}, mode == 1, 1);
		i_line_peer.run(mode * 3);
		chk(busy === 1'b1, "rx busy");
		put(END_MARK, mode == 1, 0);
		put(END_MARK, mode == 1, 0);
		i_line_peer.run(mode * 3);
		repeat (2) @(posedge aclk);
		chk(good === (mode != 2), "rx good");
		chk(irq === (mode != 2), "irq level");
		rd(A_IRQ_STAT, (mode == 2) ? 34'h4 : 34'h2, 34'h6);
		if (mode != 2) begin
			rd(A_RXINFO, {18'h0, hdr, 8'h01}, 34'h3FFFFFFFF);
			rd(12'h400, {26'h0, dat}, 34'h3FFFFFFFF);
		end
		wr(A_IRQ_STAT, 32'h7);
		@(posedge aclk);
		chk(irq === 1'b0, "irq clear");
	endtask

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (90) @(posedge aclk);
		chk(lamp === 1'b0, "lamp early");
		repeat (20) @(posedge aclk);
		v0 = tx_led;
		chk(lamp === 1'b1 && busy === v0, "lamp on");
		repeat (50) @(posedge aclk);
		chk(tx_led === ~v0, "blink");
		for (int k = 0; k < 4; k++) begin
			@(posedge aclk);
			sel_hi <= k[1];
			sel_lo <= k[0];
			repeat (3) @(posedge aclk);
			rd(A_STATUS, {9'h0, 9'(256 + k), 16'h0}, 34'h1FF0000);
		end
		rd(12'hFFC, {2'h2, 32'h0}, 34'h3FFFFFFFF);
		// receive buffer is read only from the bus
		exp_bresp = RESP_SLVERR;
		wr(12'h400, 32'h0);
		exp_bresp = RESP_OKAY;
		wr(A_IRQ_MASK, 32'h3);
		wr(A_CTRL, 32'h2);
		for (int m = 0; m < 3; m++)
			pkt(m);
		wr(A_TXCFG, {16'h0, hdr, 8'h01});
		wr(12'h200, {24'h0, dat});
		wr(A_CTRL, 32'h3);
		i = 0;
		while (tx_en !== 1'b1 && i < BIT_CLK + 100) begin
			@(posedge aclk);
			i++;
		end
		// indicator follows the state one register later
		@(posedge aclk);
		chk(tx_en === 1'b1 && tx_led === 1'b1, "tx start");
		repeat (75) @(posedge aclk);
		v0 = tx_out;
		repeat (BIT_CLK) @(posedge aclk);
		chk(tx_out === ~v0, "second bit");
		repeat (BIT_CLK) @(posedge aclk);
		chk(tx_out === v0 && tx_en === 1'b1 && tx_led === 1'b1,
			"third bit");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(tx_en === 1'b0 && tx_led === 1'b0 && awready === 1'b1, "rst");
		aresetn <= 1'b1;
		wrap_up;
	end
endmodule
